// *** verilog/srs_consts.svh ***
// startup release sequencer: offsets, fields, reset values
// assumes 32-bit apb data, one word per register
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH
`define SRS_AW 12
`define SRS_CTRL_OFF 12'h000
`define SRS_CFG_OFF 12'h004
`define SRS_LMASK_OFF 12'h008
`define SRS_STAT_OFF 12'h00c
`define SRS_CTRL_START 0
`define SRS_CFG_TRI_LSB 0
`define SRS_CFG_WE_LSB 4
`define SRS_CFG_CPL_LSB 8
`define SRS_CFG_LCK_LSB 12
`define SRS_CFG_CLK_LSB 16
`define SRS_CFG_DRIVE 20
`define SRS_CFG_PIPE 21
`define SRS_TRI_RST 3'h5
`define SRS_WE_RST 3'h6
`define SRS_CPL_RST 3'h4
`define SRS_LCK_RST 3'h7
`define SRS_SEL_RETAIN 3'h0
`define SRS_SEL_WAIT_CPL 3'h7
`define SRS_LCK_NO_WAIT 3'h7
`define SRS_LAST_PHASE 3'h6
`endif

// *** verilog/srs_pkg.sv ***
// startup release sequencer: types
// enum codes are set here; offsets and reset values are in srs_consts.svh
package srs_pkg;
  typedef enum logic [1:0] {
    SRS_IDLE = 2'h0,
    SRS_RUN = 2'h1,
    SRS_USER = 2'h3
  } srs_state_t;
  typedef enum logic [1:0] {
    SRS_CLK_CFG = 2'h0,
    SRS_CLK_USER = 2'h1,
    SRS_CLK_TEST = 2'h2
  } srs_clk_sel_t;
  typedef struct packed {
    logic pipe;
    logic drive;
    srs_clk_sel_t clk;
    logic [2:0] lck;
    logic [2:0] cpl;
    logic [2:0] we;
    logic [2:0] tri_sel;
  } srs_cfg_t;
endpackage

// *** verilog/srs_sequencer.sv ***
// startup release sequencer: apb registers, phase walk, pin control
// assumes all inputs synchronous to core_clk; clocks arrive as levels
// What this block does
// - release io hold at chosen phase, default 5
// - io stays hi-z until hold released
// - wait-complete mode holds until pin high
// - retain code keeps present hold, write enable and complete phase; lock phase always written
// - no_lock_wait never stalls for lock
// - lock phase stalls until selected managers lock
// - drive off: stop pulling low, float high
// - drive on: actively drive pin high
// - pipeline off: pin input feeds directly
// - pipeline on: one register stage inserted
// - pipelined: release on first startup edge after high
// - startup clock chosen by clock select
// - complete pin activates at chosen phase, default 4
// - write enable asserts at chosen phase, default 6
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "srs_consts.svh"
module srs_sequencer import srs_pkg::*; #(
  parameter int NUM_CM = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SRS_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // alternate startup clocks, sampled as levels
  input wire logic user_startup_clock,
  input wire logic test_clock,
  // clock managers
  input wire logic [NUM_CM-1:0] clock_lock_flag,
  // configuration-complete pin, open drain or driven
  input wire logic config_complete_pin_i,
  output logic config_complete_pin_o,
  output logic config_complete_pin_oe_n,
  // global controls
  output logic global_tristate,
  output logic global_write_enable
);
  // ==========================================================
  // register state
  srs_cfg_t cfg_q;
  logic [NUM_CM-1:0] lock_mask_q;
  srs_state_t state_q;
  logic [2:0] phase_q;
  logic tri_hold_q;
  logic we_q;
  logic cpl_act_q;
  logic cpl_pipe_q;
  logic user_clk_q;
  logic test_clk_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic start_q;

  // ==========================================================
  // apb decode
  logic setup;
  logic wr_acc;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] status;
  assign setup = psel & ~penable & ~pready_q;
  assign wr_acc = psel & penable & pready_q & pwrite;
  assign mapped = (paddr == `SRS_CTRL_OFF) | (paddr == `SRS_CFG_OFF) |
                  (paddr == `SRS_LMASK_OFF) | (paddr == `SRS_STAT_OFF);

  always_comb begin
    rd_mux = 32'h0;
    case (paddr)
      `SRS_CFG_OFF: rd_mux = {10'h0, cfg_q.pipe, cfg_q.drive, 2'h0, cfg_q.clk,
                               1'h0, cfg_q.lck, 1'h0, cfg_q.cpl, 1'h0, cfg_q.we,
                               1'h0, cfg_q.tri_sel};
      `SRS_LMASK_OFF: rd_mux = 32'(lock_mask_q);
      `SRS_STAT_OFF: rd_mux = status;
      default: rd_mux = 32'h0;
    endcase
  end

  // no wait state: pready rises in the first access cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ==========================================================
  // configuration registers
  logic [2:0] w_tri;
  logic [2:0] w_we;
  logic [2:0] w_cpl;
  assign w_tri = pwdata[`SRS_CFG_TRI_LSB +: 3];
  assign w_we = pwdata[`SRS_CFG_WE_LSB +: 3];
  assign w_cpl = pwdata[`SRS_CFG_CPL_LSB +: 3];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q.tri_sel <= `SRS_TRI_RST;
      cfg_q.we <= `SRS_WE_RST;
      cfg_q.cpl <= `SRS_CPL_RST;
      cfg_q.lck <= `SRS_LCK_RST;
      cfg_q.clk <= SRS_CLK_CFG;
      cfg_q.drive <= 1'b0;
      cfg_q.pipe <= 1'b0;
      lock_mask_q <= '0;
    end else if (wr_acc && paddr == `SRS_CFG_OFF) begin
      if (w_tri != `SRS_SEL_RETAIN) begin
        cfg_q.tri_sel <= w_tri;
      end
      if (w_we != `SRS_SEL_RETAIN) begin
        cfg_q.we <= w_we;
      end
      if (w_cpl != `SRS_SEL_RETAIN && w_cpl != `SRS_SEL_WAIT_CPL) begin
        cfg_q.cpl <= w_cpl;
      end
      cfg_q.lck <= pwdata[`SRS_CFG_LCK_LSB +: 3];
      if (pwdata[`SRS_CFG_CLK_LSB +: 2] != 2'h3) begin
        cfg_q.clk <= srs_clk_sel_t'(pwdata[`SRS_CFG_CLK_LSB +: 2]);
      end
      cfg_q.drive <= pwdata[`SRS_CFG_DRIVE];
      cfg_q.pipe <= pwdata[`SRS_CFG_PIPE];
    end else if (wr_acc && paddr == `SRS_LMASK_OFF) begin
      lock_mask_q <= pwdata[NUM_CM-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_q <= 1'b0;
    end else begin
      start_q <= wr_acc & (paddr == `SRS_CTRL_OFF) & pwdata[`SRS_CTRL_START];
    end
  end

  // ==========================================================
  // startup clock: enable pulse on each chosen rising edge
  logic tick;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      user_clk_q <= 1'b0;
      test_clk_q <= 1'b0;
    end else begin
      user_clk_q <= user_startup_clock;
      test_clk_q <= test_clock;
    end
  end
  always_comb begin
    case (cfg_q.clk)
      SRS_CLK_USER: tick = user_startup_clock & ~user_clk_q;
      SRS_CLK_TEST: tick = test_clock & ~test_clk_q;
      default: tick = 1'b1;
    endcase
  end

  // ==========================================================
  // complete pin input path
  logic cpl_in;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpl_pipe_q <= 1'b0;
    end else begin
      cpl_pipe_q <= config_complete_pin_i;
    end
  end
  assign cpl_in = cfg_q.pipe ? cpl_pipe_q : config_complete_pin_i;

  // ==========================================================
  // phase walk
  logic all_clock_lock_flag;
  logic lock_stall;
  logic cpl_stall;
  logic advance;
  logic [2:0] nxt_phase;
  logic tri_wait;
  logic we_wait;
  assign all_clock_lock_flag = &(clock_lock_flag | ~lock_mask_q);
  assign lock_stall = (cfg_q.lck != `SRS_LCK_NO_WAIT) && (phase_q == cfg_q.lck) &&
                      !all_clock_lock_flag;
  assign tri_wait = cfg_q.tri_sel == `SRS_SEL_WAIT_CPL;
  assign we_wait = cfg_q.we == `SRS_SEL_WAIT_CPL;
  assign cpl_stall = (phase_q == `SRS_LAST_PHASE) && (tri_wait || we_wait) && !cpl_in;
  assign advance = tick && state_q == SRS_RUN && !lock_stall && !cpl_stall;
  assign nxt_phase = phase_q + 3'h1;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SRS_IDLE;
      phase_q <= 3'h0;
    end else if (start_q) begin
      state_q <= SRS_RUN;
      phase_q <= 3'h0;
    end else begin
      case (state_q)
        SRS_RUN: begin
          if (advance && phase_q == `SRS_LAST_PHASE) begin
            state_q <= SRS_USER;
          end else if (advance) begin
            phase_q <= nxt_phase;
          end
        end
        SRS_IDLE, SRS_USER: state_q <= state_q;
        default: state_q <= SRS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // global three-state hold and write enable
  logic tri_rel;
  logic we_set;
  logic cpl_set;
  assign tri_rel = tri_wait ? (tick && state_q == SRS_RUN && cpl_in)
                            : (advance && nxt_phase >= cfg_q.tri_sel);
  assign we_set = we_wait ? (tick && state_q == SRS_RUN && cpl_in)
                          : (advance && nxt_phase >= cfg_q.we);
  assign cpl_set = advance && nxt_phase >= cfg_q.cpl;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tri_hold_q <= 1'b1;
    end else if (start_q) begin
      tri_hold_q <= 1'b1;
    end else if (tri_rel) begin
      tri_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      we_q <= 1'b0;
    end else if (start_q) begin
      we_q <= 1'b0;
    end else if (we_set) begin
      we_q <= 1'b1;
    end
  end
  assign global_tristate = tri_hold_q;
  assign global_write_enable = we_q;

  // ==========================================================
  // complete pin drive; chain must hold one active driver at most
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpl_act_q <= 1'b0;
    end else if (start_q) begin
      cpl_act_q <= 1'b0;
    end else if (cpl_set) begin
      cpl_act_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_complete_pin_o <= 1'b0;
      config_complete_pin_oe_n <= 1'b0;
    end else if (!(cpl_act_q || cpl_set) || start_q) begin
      config_complete_pin_o <= 1'b0;
      config_complete_pin_oe_n <= 1'b0;
    end else begin
      config_complete_pin_o <= cfg_q.drive;
      config_complete_pin_oe_n <= ~cfg_q.drive;
    end
  end

  assign status = {18'h0, lock_stall | cpl_stall, all_clock_lock_flag, cpl_act_q, cpl_in,
                   we_q, tri_hold_q, 2'h0, state_q, 1'h0, phase_q};

  // ==========================================================
  // checks
  sequence s_advance;
    state_q == SRS_RUN && tick && !lock_stall && !cpl_stall;
  endsequence
  sequence s_enter_cpl;
    s_advance ##0 nxt_phase == cfg_q.cpl && !cpl_act_q && !start_q;
  endsequence

  chk_hold_release: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(tri_hold_q) |-> $past(tri_wait) || $past(phase_q) + 3'h1 >= $past(cfg_q.tri_sel))
    else $error("io hold released before its phase");
  chk_wait_complete: assert property (@(posedge core_clk) disable iff (!rst_n)
    (tri_hold_q && tri_wait && !cpl_in && !start_q) |=> tri_hold_q)
    else $error("io hold released without complete pin");
  chk_no_lock_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_q.lck == `SRS_LCK_NO_WAIT && state_q == SRS_RUN && tick && !start_q &&
     phase_q != `SRS_LAST_PHASE) |=> phase_q == $past(phase_q) + 3'h1)
    else $error("phase stalled with no lock wait");
  chk_lock_stall: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == SRS_RUN && phase_q == cfg_q.lck && !all_clock_lock_flag && !start_q)
    |=> phase_q == $past(phase_q) && state_q == SRS_RUN)
    else $error("phase moved before clock lock");
  chk_float_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_enter_cpl ##0 !cfg_q.drive |=> config_complete_pin_oe_n)
    else $error("complete pin not released");
  chk_drive_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_enter_cpl ##0 cfg_q.drive
    |=> config_complete_pin_o && !config_complete_pin_oe_n)
    else $error("complete pin not driven high");
  chk_pin_direct: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!cfg_q.pipe && tri_wait && tri_hold_q && state_q == SRS_RUN && tick && !start_q &&
     config_complete_pin_i) |=> !tri_hold_q)
    else $error("complete input delayed without pipeline");
  chk_pin_staged: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cfg_q.pipe && tri_wait && tri_hold_q && !start_q && !$past(config_complete_pin_i))
    |=> tri_hold_q)
    else $error("complete input not staged once");
  chk_we_phase: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_advance ##0 (!we_wait && nxt_phase == cfg_q.we && !start_q) |=> we_q)
    else $error("write enable late");
  chk_low_before: assert property (@(posedge core_clk) disable iff (!rst_n)
    !cpl_act_q ##1 !cpl_act_q |-> !config_complete_pin_o && !config_complete_pin_oe_n)
    else $error("complete pin released early");
  chk_restart_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    start_q |=> tri_hold_q && !we_q && phase_q == 3'h0)
    else $error("restart left io released");
  chk_tick_only: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == SRS_RUN && !tick && !start_q) |=> phase_q == $past(phase_q))
    else $error("phase moved without startup clock");
  chk_single_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == SRS_RUN && !start_q) |=>
    (phase_q == $past(phase_q) || phase_q == $past(phase_q) + 3'h1))
    else $error("phase skipped a step");
endmodule
`default_nettype wire

// *** verification/srs_chain_peer.sv ***
// chained peer device on the shared complete wire, with pull-up
// assumes the bench decides when the peer lets go of the wire
`timescale 1ns/100ps
`default_nettype none
// ==========
// peer
module srs_chain_peer (
  // control from bench
  input wire logic hold_low,
  // design side of the pin
  input wire logic dut_o,
  input wire logic dut_oe_n,
  // resolved wire
  output logic pin_level
);
  always_comb begin
    pin_level = 1'h1;
    if (!dut_oe_n) begin
      pin_level = dut_o;
    end
    // peer only ever pulls low, never drives high
    if (hold_low) begin
      pin_level = 1'h0;
    end
  end
endmodule
`default_nettype wire

// *** verification/srs_sequencer_tb.sv ***
// bench for the startup release sequencer
// assumes srs_chain_peer resolves the complete wire
`timescale 1ns/100ps
`default_nettype none
`include "srs_consts.svh"
module srs_sequencer_tb;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pin_o, pin_oe_n, pin_level, g_tri, g_we;
  logic user_clk = 1'h0;
  logic test_clk = 1'h0;
  logic [3:0] lock_q = 4'h0;
  logic hold_low = 1'h0;
  logic [3:0] div_q = 4'h0;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int checks_done = 0;
  int p, t, w, d0, d1;
  // ==========
  // clocks
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    div_q <= div_q + 4'h1;
    user_clk <= div_q[2];
    test_clk <= div_q[3];
  end
  srs_sequencer #(.NUM_CM(4)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .user_startup_clock(user_clk), .test_clock(test_clk),
    .clock_lock_flag(lock_q), .config_complete_pin_i(pin_level),
    .config_complete_pin_o(pin_o), .config_complete_pin_oe_n(pin_oe_n),
    .global_tristate(g_tri), .global_write_enable(g_we));
  srs_chain_peer peer_u (.hold_low(hold_low), .dut_o(pin_o), .dut_oe_n(pin_oe_n),
    .pin_level(pin_level));
  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  function automatic logic [31:0] cfg(input logic [2:0] tp, wp, cp, lp,
      input logic [1:0] cs, input logic drv, pip);
    return {10'h0, pip, drv, 2'h0, cs, 1'h0, lp, 1'h0, cp, 1'h0, wp, 1'h0, tp};
  endfunction
  // starts if asked, then logs the cycle of each output change
  task automatic run(input logic go, output int rp, rt, rw);
    int n;
    rp = -1;
    rt = -1;
    rw = -1;
    if (go) apb(1'h1, `SRS_CTRL_OFF, 32'h1);
    @(posedge core_clk);
    for (n = 0; n < 200; n++) begin
      @(negedge core_clk);
      if (n == 0) chk(g_tri, 1'h1);
      if (rp < 0 && (pin_oe_n === 1'h1 || pin_o === 1'h1)) rp = n;
      if (rt < 0 && g_tri === 1'h0) rt = n;
      if (rw < 0 && g_we === 1'h1) rw = n;
    end
  endtask
  task automatic wait_cpl(input logic pip, output int d);
    apb(1'h1, `SRS_CFG_OFF, cfg(3'h7, 3'h6, 3'h4, 3'h7, 2'h0, 1'h0, pip));
    hold_low <= 1'h1;
    apb(1'h1, `SRS_CTRL_OFF, 32'h1);
    repeat (15) @(negedge core_clk);
    chk(g_tri, 1'h1);
    @(posedge core_clk);
    hold_low <= 1'h0;
    d = 0;
    do begin
      @(negedge core_clk);
      d++;
    end while (g_tri !== 1'h0 && d < 30);
  endtask
  // ==========
  // tests
  initial begin
    #1000000;
    bad_count++;
    results();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    apb(1'h0, `SRS_CFG_OFF, 32'h0);
    chk(rd, 32'h7465);
    apb(1'h0, `SRS_LMASK_OFF, 32'h0);
    chk(rd, 32'h0);
    chk(g_tri, 1'h1);
    apb(1'h1, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'h0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, `SRS_LMASK_OFF, 32'hf);
    run(1'h1, p, t, w);
    chk(32'(p), 32'h4);
    chk(32'(t - p), 32'h1);
    chk(32'(w - t), 32'h1);
    chk(pin_oe_n, 1'h1);
    chk(pin_level, 1'h1);
    apb(1'h0, `SRS_STAT_OFF, 32'h0);
    chk(rd, 32'he36);
    for (int k = 1; k <= 6; k++) begin
      apb(1'h1, `SRS_CFG_OFF, cfg(3'(k), 3'(7 - k), 3'(7 - k), 3'h7, 2'h0, 1'h0, 1'h0));
      run(1'h1, p, t, w);
      chk(32'(p), 32'(7 - k));
      chk(32'(t), 32'(k));
      chk(32'(w), 32'(7 - k));
    end
    apb(1'h1, `SRS_CFG_OFF, cfg(3'h0, 3'h0, 3'h0, 3'h7, 2'h3, 1'h1, 1'h0));
    apb(1'h0, `SRS_CFG_OFF, 32'h0);
    chk(rd, 32'h107116);
    run(1'h1, p, t, w);
    chk(32'(p), 32'h1);
    chk(32'(t), 32'h6);
    chk(32'(w), 32'h1);
    chk(pin_o, 1'h1);
    chk(pin_oe_n, 1'h0);
    for (int c = 1; c <= 2; c++) begin
      apb(1'h1, `SRS_CFG_OFF, cfg(3'h5, 3'h6, 3'h4, 3'h7, 2'(c), 1'h0, 1'h0));
      run(1'h1, p, t, w);
      chk(32'(t - p), 32'(8 * c));
      chk(32'(w - t), 32'(8 * c));
    end
    apb(1'h1, `SRS_LMASK_OFF, 32'h5);
    apb(1'h1, `SRS_CFG_OFF, cfg(3'h5, 3'h6, 3'h4, 3'h2, 2'h0, 1'h0, 1'h0));
    lock_q <= 4'h1;
    apb(1'h1, `SRS_CTRL_OFF, 32'h1);
    repeat (12) @(negedge core_clk);
    chk(g_tri, 1'h1);
    chk(pin_oe_n, 1'h0);
    @(posedge core_clk);
    lock_q <= 4'h5;
    run(1'h0, p, t, w);
    chk(32'(t - p), 32'h1);
    wait_cpl(1'h0, d0);
    wait_cpl(1'h1, d1);
    chk(32'(d0), 32'h2);
    chk(32'(d1), 32'h3);
    chk(32'(d1 - d0), 32'h1);
    results();
  end
endmodule
`default_nettype wire
